//--- design/flash_cmd_regs.vh
// offsets, field positions and command codes for the flash command controller
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH

// software register offsets (byte addresses)
`define OFS_CMD 8'h00
`define OFS_ADDR 8'h04
`define OFS_LEN 8'h08
`define OFS_TXHI 8'h0c
`define OFS_TXLO 8'h10
`define OFS_RXHI 8'h14
`define OFS_RXLO 8'h18
`define OFS_STAT 8'h1c

// field positions
`define CMD_OCT_BIT 8
`define STAT_BUSY 0
`define STAT_ARMED 1
`define STAT_BAD 2
`define STAT_DONE 3

// single-wire register commands
`define OP_RD_STATE 8'h05
`define OP_RD_CFG 8'h15
`define OP_RD_CFG2 8'h71
`define OP_WR_CFG2 8'h72
`define OP_RD_SECURE 8'h2b
`define OP_WR_SECURE 8'h2f
`define OP_RD_BOOT 8'h16
`define OP_WR_BOOT 8'h17
`define OP_ER_BOOT 8'h18
`define OP_PROG_SOLID 8'he3
`define OP_RD_PASS 8'h27
`define OP_WR_PASS 8'h28

// device operation, both modes except PSEL, which is octal only
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PSEL 8'h68
`define OP_RST_ARM 8'h66
`define OP_RST 8'h99

// octal array access
`define OP_OCT_READ 8'hec
`define OP_OCT_PROG 8'h12
`define OP_OCT_SECT 8'h21
`define OP_OCT_BLK 8'hdc
`define OP_OCT_CHIP 8'h60
`define OP_OCT_CHIP2 8'hc7

// lookup entry fields: known, read, flexible length, zero address
`define TAB_KNOWN 15
`define TAB_RD 14
`define TAB_FLEX 13
`define TAB_ZADDR 12
`define TAB_DMY_CFG 5'h1f

`endif

//--- design/flash_register_command_decoder.v
// host controller issuing register and array commands to a serial nor flash
// Contract
// - status read: code 05, no address, no dummy, one byte returned
// - configuration read: code 15, no address, no dummy, one byte returned
// - second configuration read: code 71, four address bytes, one byte back
// - second configuration write: code 72, four address bytes, one byte out
// - security read: code 2b, no address, no dummy cycles
// - security write: code 2f, opcode only
// - boot-vector read: code 16, one to four bytes, ends at select rise
// - boot-vector write: code 17, exactly four data bytes
// - boot-vector erase: code 18, opcode only
// - solid-protect program: code e3, four address bytes, no data
// - passcode read: code 27, zero address, eight dummy, eight bytes back
// - passcode write: code 28, zero address, eight bytes out
// - reset-arm must precede memory reset
// - only defined command codes are sent
// - octal commands send opcode then its complement
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"

module flash_register_command_decoder #(
	parameter [7:0] HALF = 8'd2,
	parameter [7:0] GAP = 8'd4
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// software register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	// flash pins
	output reg sclk,
	output reg cs_n,
	output reg [7:0] io_out,
	output reg [7:0] io_oe,
	input wire [7:0] io_in
);

localparam [1:0] S_IDLE = 2'd0;
localparam [1:0] S_RUN = 2'd1;
localparam [1:0] S_GAP = 2'd2;
localparam [2:0] P_OP = 3'd0;
localparam [2:0] P_OP2 = 3'd1;
localparam [2:0] P_ADDR = 3'd2;
localparam [2:0] P_DMY = 3'd3;
localparam [2:0] P_DATA = 3'd4;
localparam [2:0] P_END = 3'd5;
localparam [7:0] LAST = HALF * 8'd2 - 8'd1;
// entry: known, read, flex, zero addr, addr bytes[11:9], dummy[8:4], data[3:0]
function [15:0] tab;
	input [7:0] op;
	input oc;
	begin
		tab = 16'h0;
		if (!oc) begin
			case (op)
				`OP_RD_STATE, `OP_RD_CFG: tab = 16'hc001;
				`OP_RD_CFG2: tab = 16'hc801;
				`OP_WR_CFG2: tab = 16'h8801;
				`OP_RD_SECURE: tab = 16'hc001;
				`OP_WR_SECURE: tab = 16'h8000;
				`OP_RD_BOOT: tab = 16'he004;
				`OP_WR_BOOT: tab = 16'h8004;
				`OP_ER_BOOT: tab = 16'h8000;
				`OP_PROG_SOLID: tab = 16'h8800;
				`OP_RD_PASS: tab = 16'hd888;
				`OP_WR_PASS: tab = 16'h9808;
				`OP_WREN, `OP_WRDI, `OP_RST_ARM, `OP_RST: tab = 16'h8000;
				default: tab = 16'h0;
			endcase
		end else begin
			case (op)
				`OP_OCT_READ: tab = 16'he9f8;
				`OP_OCT_PROG: tab = 16'ha808;
				`OP_OCT_SECT, `OP_OCT_BLK: tab = 16'h8800;
				`OP_OCT_CHIP, `OP_OCT_CHIP2: tab = 16'h8000;
				`OP_WREN, `OP_WRDI, `OP_PSEL: tab = 16'h8000;
				`OP_RST_ARM, `OP_RST: tab = 16'h8000;
				default: tab = 16'h0;
			endcase
		end
	end
endfunction

reg [7:0] in_m;
reg [7:0] in_s;
reg [1:0] st;
reg [2:0] ph;
reg [7:0] div;
reg [7:0] gcnt;
reg [4:0] cnt;
reg [2:0] bitc;
reg [7:0] op_cur;
reg oct;
reg pend_rst;
reg armed;
reg bad;
reg done;
reg [31:0] addr_r;
reg [3:0] len_r;
reg [4:0] dcfg;
reg [31:0] cur_addr;
reg [3:0] cur_len;
reg [4:0] cur_dmy;
reg [63:0] tx;
reg [63:0] rx;
reg [7:0] rxsh;
reg [2:0] next_ph;
reg unit_last;
reg [7:0] obyte;
reg [3:0] nd;
wire [15:0] t = tab(op_cur, oct);
wire [15:0] wt = tab(wdata[7:0], wdata[`CMD_OCT_BIT]);
wire rd_cmd = t[`TAB_RD];
wire [2:0] na = t[11:9];
wire [4:0] dmy = (t[8:4] == `TAB_DMY_CFG) ? cur_dmy : t[8:4];
wire [1:0] sel = na[1:0] - 2'd1 - cnt[1:0];
wire beat_end = (st == S_RUN) && (div == LAST);
wire byte_end = oct || (bitc == 3'd7);
wire [7:0] rxbyte = oct ? in_s : {rxsh[6:0], in_s[1]};
wire drive_all = !(ph == P_DMY || (ph == P_DATA && rd_cmd));
wire cmd_wr = wr && (addr == `OFS_CMD);
wire want_rst = (wdata[7:0] == `OP_RST) && !armed;

// pin inputs are asynchronous to clk; two stages before use
always @(posedge clk or posedge rst) begin
	if (rst) begin
		in_m <= 8'h00;
		in_s <= 8'h00;
	end else begin
		in_m <= io_in;
		in_s <= in_m;
	end
end

// data length: flexible commands take the software count, zero as one, clamped to the table
always @* begin
	nd = t[3:0];
	if (t[`TAB_FLEX]) begin
		if (cur_len == 4'h0)
			nd = 4'h1;
		else if (cur_len < t[3:0])
			nd = cur_len;
	end
end

// phase order walks the table entry; empty phases are skipped
always @* begin
	next_ph = P_END;
	if (ph == P_OP && oct)
		next_ph = P_OP2;
	else if (ph <= P_OP2 && na != 3'd0)
		next_ph = P_ADDR;
	else if (ph <= P_ADDR && dmy != 5'd0)
		next_ph = P_DMY;
	else if (ph <= P_DMY && nd != 4'd0)
		next_ph = P_DATA;
end

// last unit of the current phase
always @* begin
	case (ph)
		P_ADDR: unit_last = (cnt[2:0] == na - 3'd1);
		P_DMY: unit_last = (cnt == dmy - 5'd1);
		P_DATA: unit_last = (cnt[3:0] == nd - 4'd1);
		default: unit_last = 1'b1;
	endcase
end

// outgoing byte, most significant first
always @* begin
	case (ph)
		P_OP: obyte = op_cur;
		P_OP2: obyte = ~op_cur;
		P_ADDR: obyte = cur_addr[{sel, 3'b000} +: 8];
		P_DATA: obyte = tx[{~cnt[2:0], 3'b000} +: 8];
		default: obyte = 8'h00;
	endcase
end

// software-owned settings; tx must not change while busy
always @(posedge clk or posedge rst) begin
	if (rst) begin
		addr_r <= 32'h0;
		len_r <= 4'h0;
		dcfg <= 5'h0;
		tx <= 64'h0;
	end else if (wr) begin
		case (addr)
			`OFS_ADDR: addr_r <= wdata;
			`OFS_LEN: begin
				len_r <= wdata[3:0];
				dcfg <= wdata[12:8];
			end
			`OFS_TXHI: tx[63:32] <= wdata;
			`OFS_TXLO: tx[31:0] <= wdata;
			default: ;
		endcase
	end
end

// frame sequencer and pin drivers
always @(posedge clk or posedge rst) begin
	if (rst) begin
		st <= S_IDLE;
		ph <= P_OP;
		div <= 8'h0;
		gcnt <= 8'h0;
		cnt <= 5'h0;
		bitc <= 3'h0;
		op_cur <= 8'h0;
		oct <= 1'b0;
		pend_rst <= 1'b0;
		armed <= 1'b0;
		bad <= 1'b0;
		done <= 1'b0;
		cur_addr <= 32'h0;
		cur_len <= 4'h0;
		cur_dmy <= 5'h0;
		rx <= 64'h0;
		rxsh <= 8'h0;
		sclk <= 1'b0;
		cs_n <= 1'b1;
		io_out <= 8'h00;
		io_oe <= 8'h00;
	end else begin
		case (st)
			S_IDLE: begin
				if (cmd_wr && !wt[`TAB_KNOWN]) begin
					bad <= 1'b1;
				end else if (cmd_wr) begin
					bad <= 1'b0;
					done <= 1'b0;
					oct <= wdata[`CMD_OCT_BIT];
					pend_rst <= want_rst;
					op_cur <= want_rst ? `OP_RST_ARM : wdata[7:0];
					cur_addr <= wt[`TAB_ZADDR] ? 32'h0 : addr_r;
					cur_len <= len_r;
					cur_dmy <= dcfg;
					rx <= 64'h0;
					st <= S_RUN;
					ph <= P_OP;
					cnt <= 5'h0;
					bitc <= 3'h0;
					div <= 8'h0;
					cs_n <= 1'b0;
				end
			end
			S_RUN: begin
				if (cmd_wr)
					bad <= 1'b1;
				div <= beat_end ? 8'h0 : div + 8'h1;
				// new bit goes out while clock is low
				if (div == 8'h0) begin
					io_out <= oct ? obyte : {7'h0, obyte[~bitc]};
					io_oe <= oct ? (drive_all ? 8'hff : 8'h00) : 8'h01;
				end
				if (div == HALF - 8'h1)
					sclk <= 1'b1;
				if (beat_end) begin
					sclk <= 1'b0;
					rxsh <= {rxsh[6:0], in_s[1]};
					if (ph == P_DMY || byte_end) begin
						bitc <= 3'h0;
						if (ph == P_DATA && rd_cmd)
							rx <= {rx[55:0], rxbyte};
						if (unit_last) begin
							cnt <= 5'h0;
							ph <= next_ph;
							if (next_ph == P_END) begin
								// select rise closes the frame
								st <= S_GAP;
								gcnt <= 8'h0;
								cs_n <= 1'b1;
								io_oe <= 8'h00;
								armed <= (op_cur == `OP_RST_ARM);
							end
						end else begin
							cnt <= cnt + 5'h1;
						end
					end else begin
						bitc <= bitc + 3'h1;
					end
				end
			end
			S_GAP: begin
				if (cmd_wr)
					bad <= 1'b1;
				gcnt <= gcnt + 8'h1;
				// select high time between frames, then the queued reset
				if (gcnt == GAP - 8'h1) begin
					if (pend_rst) begin
						pend_rst <= 1'b0;
						op_cur <= `OP_RST;
						st <= S_RUN;
						ph <= P_OP;
						cnt <= 5'h0;
						bitc <= 3'h0;
						div <= 8'h0;
						cs_n <= 1'b0;
					end else begin
						st <= S_IDLE;
						done <= 1'b1;
					end
				end
			end
			default: st <= S_IDLE;
		endcase
	end
end

// read data stands only in the cycle after the strobe
always @(posedge clk or posedge rst) begin
	if (rst) begin
		rdata <= 32'h0;
	end else if (rd) begin
		case (addr)
			`OFS_CMD: rdata <= {23'h0, oct, op_cur};
			`OFS_ADDR: rdata <= addr_r;
			`OFS_LEN: rdata <= {19'h0, dcfg, 4'h0, len_r};
			`OFS_TXHI: rdata <= tx[63:32];
			`OFS_TXLO: rdata <= tx[31:0];
			`OFS_RXHI: rdata <= rx[63:32];
			`OFS_RXLO: rdata <= rx[31:0];
			`OFS_STAT: rdata <= {28'h0, done, bad, armed, st != S_IDLE};
			default: rdata <= 32'h0;
		endcase
	end else begin
		rdata <= 32'h0;
	end
end
endmodule

//--- test/flash_device_model.sv
// behavioural serial flash: logs host beats, answers reads, tracks reset arming
`timescale 1ns/100ps
module flash_device_model (
	// system clock, mode flag and flash pins
	input wire clk,
	input wire sclk,
	input wire cs_n,
	input wire oct,
	input wire [7:0] io_out,
	output reg [7:0] io_in
);
	reg [7:0] log [0:31];
	reg [7:0] sh;
	reg [7:0] v;
	reg armed;
	integer nb, nbit, nf, nrst;
	initial begin
		io_in = 8'h00;
		armed = 1'b0;
		nf = 0;
		nrst = 0;
	end
	// frame opens: beat counters cleared
	always @(negedge cs_n) begin
		nb = 0;
		nbit = 0;
	end
	// inputs latched on rising clock; msb first on one wire, a byte a beat on eight
	always @(posedge sclk) begin
		sh = {sh[6:0], io_out[0]};
		nbit = nbit + 1;
		if (oct || nbit % 8 == 0) begin
			log[nb] = oct ? io_out : sh;
			nb = nb + 1;
		end
	end
	// output shifts on falling clock; byte value tells its place in the frame
	always @(negedge sclk) begin
		v = 8'h30 + nbit[10:3];
		if (oct) io_in = 8'h30 + nbit[7:0];
		else io_in[1] = v[~nbit[2:0]];
	end
	// deselected: lines change every clock so no stale bit passes for data
	always @(posedge clk) begin
		if (cs_n) io_in <= ~io_in;
	end
	// frame closes: reset takes effect only right after an arm frame
	always @(posedge cs_n) begin
		nf = nf + 1;
		if (armed && nb > 0 && log[0] == 8'h99) nrst = nrst + 1;
		armed = nb > 0 && log[0] == 8'h66;
	end
endmodule

//--- test/flash_register_command_decoder_properties.sv
// concurrent checks on the flash pins and command port of the controller
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module flash_cmd_checker #(
	parameter [7:0] HALF = 8'd2,
	parameter [7:0] GAP = 8'd4
) (
	// clock, reset and register port
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	// flash pins
	input wire sclk,
	input wire cs_n,
	input wire [7:0] io_out,
	input wire [7:0] io_oe
);
	reg [7:0] hi_n;
	reg [7:0] lo_n;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// high-phase and deselect lengths; deselect saturates so long idles never wrap
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_n <= 8'h00;
			lo_n <= 8'hff;
		end else begin
			hi_n <= sclk ? hi_n + 8'h01 : 8'h00;
			lo_n <= !cs_n ? 8'h00 : (lo_n == 8'hff ? lo_n : lo_n + 8'h01);
		end
	end
	sclk_idle_a: assert property (cs_n |-> !sclk)
		else $error("clock runs deselected");
	sclk_high_a: assert property ($fell(sclk) |-> hi_n == HALF)
		else $error("clock high length wrong");
	data_hold_a: assert property (sclk && $past(sclk) |-> $stable(io_out))
		else $error("data moved in high phase");
	frame_end_a: assert property ($rose(cs_n) |-> !sclk && io_oe == 8'h00)
		else $error("lines held after frame");
	frame_gap_a: assert property ($fell(cs_n) |-> lo_n >= GAP)
		else $error("frames too close");
	frame_start_a: assert property ($fell(cs_n) |-> ##[1:8] $rose(sclk))
		else $error("frame without clock");
	lane_use_a: assert property (io_oe == 8'h01 |-> io_out[7:1] == 7'h00)
		else $error("idle lanes driven");
	oe_shape_a: assert property (io_oe != 8'h00 |-> !cs_n && io_oe[0])
		else $error("drive outside frame");
	bad_code_a: assert property (wr && addr == `OFS_CMD && wdata[8:0] == 9'h000 && cs_n
		|=> cs_n [*8])
		else $error("undefined code sent");
endmodule
bind flash_register_command_decoder flash_cmd_checker #(.HALF(HALF), .GAP(GAP)) props (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.sclk(sclk), .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe));

//--- test/flash_register_command_decoder_tb.sv
// self-checking bench: register-driven command frames against a flash model
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module flash_register_command_decoder_tb;
	reg clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, oct = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [31:0] wdata = 32'h0, a_v, l_v, st;
	reg [63:0] tx_v;
	wire [31:0] rdata;
	wire sclk, cs_n;
	wire [7:0] io_out, io_oe, io_in;
	integer err_count = 0, n_compared = 0, i, f;
	always #12.5 clk = ~clk;
	flash_register_command_decoder DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .sclk(sclk), .cs_n(cs_n), .io_out(io_out),
		.io_oe(io_oe), .io_in(io_in));
	flash_device_model m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .oct(oct), .io_out(io_out),
		.io_in(io_in));
	task tally_and_finish;
		begin
			if (err_count == 0 && n_compared > 0) $display("Test passed");
			else $display("Test failed");
			$finish;
		end
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// one-cycle strobes, changed just after the edge
	task wreg(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	task rreg(input [7:0] a, output [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 d = rdata;
		end
	endtask
	task wait_idle;
		integer k;
		begin
			st = 32'h1;
			for (k = 0; k < 400 && st[`STAT_BUSY] !== 1'b0; k = k + 1) rreg(`OFS_STAT, st);
			if (st[`STAT_BUSY] !== 1'b0) begin
				err_count = err_count + 1;
				tally_and_finish;
			end
		end
	endtask
	// one command end to end; frame bytes rebuilt from the expected lengths
	task do_cmd(input [7:0] op, input o, input integer na, input z, input integer ntx,
		input integer nd, input integer nrd);
		integer k, p;
		reg [63:0] rx;
		begin
			a_v = $urandom;
			tx_v = {$urandom, $urandom};
			oct <= o;
			wreg(`OFS_ADDR, a_v);
			wreg(`OFS_LEN, l_v);
			wreg(`OFS_TXHI, tx_v[63:32]);
			wreg(`OFS_TXLO, tx_v[31:0]);
			wreg(`OFS_CMD, {23'h0, o, op});
			wait_idle;
			chk(m.nb, 1 + o + na + nd + ntx + nrd);
			chk(m.log[0], op);
			if (o) chk(m.log[1], {~op});
			for (k = 0; k < na; k = k + 1)
				chk(m.log[1 + o + k], z ? 8'h00 : a_v[31 - 8 * k -: 8]);
			p = 1 + o + na + nd;
			for (k = 0; k < ntx; k = k + 1) chk(m.log[p + k], tx_v[63 - 8 * k -: 8]);
			rx = 64'h0;
			for (k = 0; k < nrd; k = k + 1) rx = {rx[55:0], 8'h30 + p[7:0] + ntx[7:0] + k[7:0]};
			rreg(`OFS_RXHI, st);
			chk(st, rx[63:32]);
			rreg(`OFS_RXLO, st);
			chk(st, rx[31:0]);
		end
	endtask
	initial begin
		f = $urandom(32'h92d67554);
		l_v = 32'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		do_cmd(8'h05, 0, 0, 0, 0, 0, 1);
		do_cmd(8'h15, 0, 0, 0, 0, 0, 1);
		do_cmd(8'h71, 0, 4, 0, 0, 0, 1);
		do_cmd(8'h72, 0, 4, 0, 1, 0, 0);
		do_cmd(8'h2b, 0, 0, 0, 0, 0, 1);
		do_cmd(8'h2f, 0, 0, 0, 0, 0, 0);
		do_cmd(8'h17, 0, 0, 0, 4, 0, 0);
		do_cmd(8'h18, 0, 0, 0, 0, 0, 0);
		do_cmd(8'he3, 0, 4, 0, 0, 0, 0);
		do_cmd(8'h27, 0, 4, 1, 0, 1, 8);
		do_cmd(8'h28, 0, 4, 1, 8, 0, 0);
		// boot read length at zero, at the top and above it
		for (i = 0; i < 3; i = i + 1) begin
			l_v = i == 0 ? 0 : (i == 1 ? 4 : 5 + $urandom % 11);
			do_cmd(8'h16, 0, 0, 0, 0, 0, l_v == 0 ? 1 : (l_v > 4 ? 4 : l_v));
		end
		// undefined code, then an order while busy: both turned away
		f = m.nf;
		wreg(`OFS_CMD, 32'h0);
		rreg(`OFS_STAT, st);
		chk(st[`STAT_BAD], 1);
		chk(m.nf, f);
		// let the no-frame window after a refused code run out before the next order
		repeat (8) @(posedge clk);
		wreg(`OFS_CMD, 32'h05);
		wreg(`OFS_CMD, 32'h15);
		rreg(`OFS_STAT, st);
		chk(st[`STAT_BAD], 1);
		wait_idle;
		chk(m.log[0], 8'h05);
		// memory reset goes out armed; any other frame drops the arm
		f = m.nrst;
		wreg(`OFS_CMD, 32'h99);
		wait_idle;
		chk(m.nrst, f + 1);
		wreg(`OFS_CMD, 32'h66);
		wait_idle;
		rreg(`OFS_STAT, st);
		chk(st[`STAT_ARMED], 1);
		do_cmd(8'h05, 0, 0, 0, 0, 0, 1);
		rreg(`OFS_STAT, st);
		chk(st[`STAT_ARMED], 0);
		do_cmd(8'h06, 1, 0, 0, 0, 0, 0);
		do_cmd(8'h21, 1, 4, 0, 0, 0, 0);
		do_cmd(8'hc7, 1, 0, 0, 0, 0, 0);
		do_cmd(8'h04, 1, 0, 0, 0, 0, 0);
		do_cmd(8'h68, 1, 0, 0, 0, 0, 0);
		// octal program with a random length, octal read with set dummy and length
		l_v = 1 + $urandom % 8;
		do_cmd(8'h12, 1, 4, 0, l_v, 0, 0);
		l_v = 32'h0000_0603;
		do_cmd(8'hec, 1, 4, 0, 0, 6, 3);
		tally_and_finish;
	end
endmodule
